// ---- include/aisp_defines.vh ----
// constants for the converter interrupt select pair block
// Function
// - bits 15 and 7 of the select register read zero; writes there ignored
// - continuous mode 0: no further pulses on a line until its flag clears
// - continuous mode 1: pulse on every selected trigger, flag state ignored
// - five-bit select picks trigger 0 to 15; top bit set is invalid
// - trigger while flag already set sets the overflow bit, any mode
// - overflow clear in same cycle as hardware set: set wins
// - select register writes accepted only while write unlock is active
`ifndef AISP_DEFINES_VH
`define AISP_DEFINES_VH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define AISP_ADDR_SEL 8'h00
`define AISP_ADDR_FLAG 8'h04
`define AISP_ADDR_FLAG_CLR 8'h08
`define AISP_ADDR_OVF 8'h0c
`define AISP_ADDR_OVF_CLR 8'h10
`define AISP_ADDR_UNLOCK 8'h14
`define AISP_ADDR_IRQ_STAT 8'h18
`define AISP_ADDR_IRQ_CLR 8'h1c
`define AISP_ADDR_IRQ_EN 8'h20

// ---------------------------------------------------------------
// select register fields
// ---------------------------------------------------------------
`define AISP_SEL_WMASK 16'h7f7f
`define AISP_SEL_RESET 16'h0000
`define AISP_UP_LSB 8
`define AISP_LO_LSB 0
`define AISP_F_CONT 6
`define AISP_F_EN 5
`define AISP_F_SRC_TOP 4

// ---------------------------------------------------------------
// axi responses
// ---------------------------------------------------------------
`define AISP_RESP_OKAY 2'b00
`define AISP_RESP_SLVERR 2'b10

`endif

// ---- tb/aisp_eoc_seq.sv ----
// conversion sequencer model issuing end-of-conversion pulses
`timescale 1ns/100ps
module aisp_eoc_seq (
    input wire aclk,
    output logic [15:0] eoc_pulse
);
    // ---------------------------------------------------------------
    // pulse generator
    // ---------------------------------------------------------------
    initial eoc_pulse = 16'h0000;
    // hold of at least 1 cycle, else the input synchroniser may miss it
    task fire(input int idx, input int hold);
        @(posedge aclk);
        eoc_pulse[idx] <= 1'b1;
        repeat (hold) @(posedge aclk);
        eoc_pulse[idx] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
endmodule

// ---- tb/aisp_properties.sv ----
// port-level assertions for the interrupt select pair
`timescale 1ns/100ps
module aisp_props (
    input wire aclk,
    input wire aresetn,
    input wire [15:0] eoc_pulse,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire converter_interrupt_upper,
    input wire converter_interrupt_lower,
    input wire irq_ff
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rsv_read_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[15] && !s_axi_rdata[7])
        else $error("reserved bit read as one");
    a_lo_pulse_cause: assert property (converter_interrupt_lower |-> $past(|eoc_pulse, 3))
        else $error("lower pulse without trigger");
    a_up_pulse_cause: assert property (converter_interrupt_upper |-> $past(|eoc_pulse, 3))
        else $error("upper pulse without trigger");
    a_lo_pulse_single: assert property (converter_interrupt_lower |=> !converter_interrupt_lower[*3])
        else $error("lower pulse too long");
    a_up_pulse_single: assert property ($rose(converter_interrupt_upper) |=> $fell(converter_interrupt_upper))
        else $error("upper pulse too long");
    a_reset_quiet: assert property (disable iff (1'b0) $rose(aresetn) |-> !irq_ff && !converter_interrupt_lower && !converter_interrupt_upper)
        else $error("output active out of reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_taken: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready)
        else $error("read address not taken");
    a_rvalid_after: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read data before address taken");
    a_bresp_after: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write response before handshakes");
endmodule

// ---- tb/test_adc_interrupt_select_pair.sv ----
// self-checking bench for the interrupt select pair
`timescale 1ns/100ps
`include "aisp_defines.vh"
module test_adc_interrupt_select_pair;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, converter_interrupt_upper, converter_interrupt_lower, irq_ff;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] eoc_pulse;
    int error_cnt, tests_run, n_up, n_lo, cyc, u0, l0;
    typedef struct {logic [15:0] sel; int idx; int exp;} aisp_row_t;
    aisp_row_t rows[7] = '{'{16'h0025, 5, 'h01}, '{16'h0025, 4, 'h00}, '{16'h0005, 5, 'h00},
        '{16'h2a00, 10, 'h10}, '{16'h2f2f, 15, 'h11}, '{16'h0030, 0, 'h00}, '{16'h3000, 0, 'h00}};
    aisp_top DUT (.*);
    aisp_eoc_seq seq (.aclk(aclk), .eoc_pulse(eoc_pulse));
    // ---------------------------------------------------------------
    // clock, pulse counters, watchdog
    // ---------------------------------------------------------------
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        n_up <= n_up + converter_interrupt_upper;
        n_lo <= n_lo + converter_interrupt_lower;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out;
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task close_out;
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // leading edge wait keeps two tasks from driving bready in one step
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk("rdata", v, e);
    endtask
    // count is upper pulses times 16 plus lower pulses
    task pc(input int idx, input int hold, input int e);
        u0 = n_up;
        l0 = n_lo;
        seq.fire(idx, hold);
        chk("pulses", (n_up - u0) * 16 + n_lo - l0, e);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        aresetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        chk("irq", irq_ff, 0);
        rchk(`AISP_ADDR_SEL, 0);
        axw(`AISP_ADDR_SEL, 32'h2025);
        chk("resp", resp, `AISP_RESP_OKAY);
        rchk(`AISP_ADDR_SEL, 0);
        pc(5, 2, 'h00);
        axw(`AISP_ADDR_UNLOCK, 1);
        foreach (rows[i]) begin
            axw(`AISP_ADDR_SEL, rows[i].sel);
            pc(rows[i].idx, 2, rows[i].exp);
            axw(`AISP_ADDR_FLAG_CLR, 3);
        end
        axw(`AISP_ADDR_SEL, 32'hffff);
        rchk(`AISP_ADDR_SEL, 32'h7f7f);
        axw(`AISP_ADDR_OVF_CLR, 3);
        axw(`AISP_ADDR_IRQ_CLR, 32'hf);
        axw(`AISP_ADDR_IRQ_EN, 5);
        axw(`AISP_ADDR_SEL, 32'h0021);
        pc(1, 5, 'h01);
        chk("irq", irq_ff, 1);
        pc(1, 2, 'h00);
        rchk(`AISP_ADDR_FLAG, 1);
        rchk(`AISP_ADDR_OVF, 1);
        rchk(`AISP_ADDR_IRQ_STAT, 5);
        axw(`AISP_ADDR_IRQ_EN, 0);
        rchk(`AISP_ADDR_IRQ_EN, 0);
        chk("irq", irq_ff, 0);
        axw(`AISP_ADDR_IRQ_EN, 5);
        axw(`AISP_ADDR_IRQ_CLR, 5);
        rchk(`AISP_ADDR_IRQ_STAT, 0);
        chk("irq", irq_ff, 0);
        axw(`AISP_ADDR_FLAG_CLR, 1);
        pc(1, 2, 'h01);
        axw(`AISP_ADDR_OVF_CLR, 3);
        for (int i = 0; i < 16; i++) begin
            axw(`AISP_ADDR_SEL, 32'h6060 | (i << 8) | i);
            pc(i, 2, 'h11);
        end
        rchk(`AISP_ADDR_OVF, 3);
        axw(`AISP_ADDR_OVF_CLR, 3);
        rchk(`AISP_ADDR_OVF, 0);
        // clear write lands on the very edge that sets overflow again
        fork
            seq.fire(15, 2);
            begin
                repeat (2) @(posedge aclk);
                axw(`AISP_ADDR_OVF_CLR, 3);
            end
        join
        rchk(`AISP_ADDR_OVF, 3);
        axr(8'h24);
        chk("resp", resp, `AISP_RESP_SLVERR);
        chk("rdata", v, 0);
        close_out;
    end
endmodule
bind aisp_top aisp_props u_props (.*);

// ---- verilog/aisp_line.v ----
// one interrupt line: source pick, flag, overflow and pulse
`timescale 1ns/100ps
`include "aisp_defines.vh"
module aisp_line (
    aclk,
    aresetn,
    cfg,
    eoc,
    flag_clr,
    ovf_clr,
    pulse_ff,
    flag_ff,
    ovf_ff,
    ovf_evt_ff
);
    input wire aclk;
    input wire aresetn;
    input wire [6:0] cfg;
    input wire [15:0] eoc;
    input wire flag_clr;
    input wire ovf_clr;
    output reg pulse_ff;
    output reg flag_ff;
    output reg ovf_ff;
    output reg ovf_evt_ff;

    wire cont = cfg[`AISP_F_CONT];
    wire en = cfg[`AISP_F_EN];
    // invalid selections never fire
    wire trig = en & ~cfg[`AISP_F_SRC_TOP] & eoc[cfg[3:0]];
    wire ovf_set = trig & flag_ff;
    wire fire = trig & (cont | ~flag_ff);
    wire nxt_pulse = fire;
    // set beats clear so a trigger in the clearing cycle is kept
    wire nxt_flag = trig | (flag_ff & ~flag_clr);
    wire nxt_ovf = ovf_set | (ovf_ff & ~ovf_clr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_ff <= 1'b0;
            flag_ff <= 1'b0;
            ovf_ff <= 1'b0;
            ovf_evt_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
            flag_ff <= nxt_flag;
            ovf_ff <= nxt_ovf;
            ovf_evt_ff <= ovf_set;
        end
    end
endmodule

// ---- verilog/aisp_top.v ----
// interrupt select pair with axi4-lite register access
`timescale 1ns/100ps
`include "aisp_defines.vh"
module aisp_top (
    aclk,
    aresetn,
    eoc_pulse,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    converter_interrupt_upper,
    converter_interrupt_lower,
    irq_ff
);
    input wire aclk;
    input wire aresetn;
    input wire [15:0] eoc_pulse;
    input wire [7:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [7:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    output wire converter_interrupt_upper;
    output wire converter_interrupt_lower;
    output reg irq_ff;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg [15:0] interrupt_pair_select_ff;
    reg protected_write_unlock_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_en_ff;
    reg [7:0] awaddr_ff;
    reg aw_held_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg w_held_ff;
    reg [15:0] eoc_meta_ff;
    reg [15:0] eoc_sync_ff;
    reg [15:0] eoc_last_ff;
    reg b_pend_ff;
    reg r_pend_ff;

    wire [1:0] interrupt_flag_bits;
    wire [1:0] interrupt_overflow_bits;
    wire [1:0] line_pulse;
    wire [1:0] line_ovf_evt;

    // ---------------------------------------------------------------
    // trigger capture: pulses from outside, synchronised then edge-made
    // ---------------------------------------------------------------
    wire [15:0] eoc_rise = eoc_sync_ff & ~eoc_last_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            eoc_meta_ff <= 16'h0000;
            eoc_sync_ff <= 16'h0000;
            eoc_last_ff <= 16'h0000;
        end else begin
            eoc_meta_ff <= eoc_pulse;
            eoc_sync_ff <= eoc_meta_ff;
            eoc_last_ff <= eoc_sync_ff;
        end
    end

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    wire aw_ok = aw_held_ff | s_axi_awvalid;
    wire w_ok = w_held_ff | s_axi_wvalid;
    wire wr_go = aw_ok & w_ok & ~s_axi_bvalid & ~b_pend_ff;
    wire [7:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;

    function hit;
        input [7:0] a;
        input [7:0] r;
        begin
            hit = (a[7:2] == r[7:2]);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[7:2] <= `AISP_ADDR_IRQ_EN >> 2);
        end
    endfunction

    wire wr_sel = wr_go & hit(wr_addr, `AISP_ADDR_SEL);
    wire [1:0] flag_clr = (wr_go & hit(wr_addr, `AISP_ADDR_FLAG_CLR) & wr_strb[0]) ?
        wr_data[1:0] : 2'b00;
    wire [1:0] ovf_clr = (wr_go & hit(wr_addr, `AISP_ADDR_OVF_CLR) & wr_strb[0]) ?
        wr_data[1:0] : 2'b00;
    wire [3:0] stat_clr = (wr_go & hit(wr_addr, `AISP_ADDR_IRQ_CLR) & wr_strb[0]) ?
        wr_data[3:0] : 4'h0;

    // reserved bits never stored, so they read back zero
    wire [15:0] sel_wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & `AISP_SEL_WMASK;
    wire [15:0] nxt_sel = (interrupt_pair_select_ff & ~sel_wmask) |
        (wr_data[15:0] & sel_wmask);
    // stat bits, msb first: upper overflow, lower overflow, upper pulse, lower pulse
    wire [3:0] stat_evt = {line_ovf_evt, line_pulse};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AISP_RESP_OKAY;
            b_pend_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            interrupt_pair_select_ff <= `AISP_SEL_RESET;
            protected_write_unlock_ff <= 1'b0;
            irq_stat_ff <= 4'h0;
            irq_en_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            b_pend_ff <= 1'b0;
            if (s_axi_awvalid & ~aw_held_ff & ~s_axi_awready & ~wr_go) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid & ~w_held_ff & ~s_axi_wready & ~wr_go) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            if (wr_go & ~s_axi_awready & ~s_axi_wready) begin
                s_axi_awready <= ~aw_held_ff;
                s_axi_wready <= ~w_held_ff;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                b_pend_ff <= 1'b1;
                s_axi_bresp <= mapped(wr_addr) ? `AISP_RESP_OKAY : `AISP_RESP_SLVERR;
                if (wr_sel & protected_write_unlock_ff) begin
                    interrupt_pair_select_ff <= nxt_sel;
                end
                if (hit(wr_addr, `AISP_ADDR_UNLOCK) & wr_strb[0]) begin
                    protected_write_unlock_ff <= wr_data[0];
                end
                if (hit(wr_addr, `AISP_ADDR_IRQ_EN) & wr_strb[0]) begin
                    irq_en_ff <= wr_data[3:0];
                end
            end
            // response only after both ready pulses have been seen
            if (b_pend_ff) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // event in the clearing cycle survives
            irq_stat_ff <= stat_evt | (irq_stat_ff & ~stat_clr);
            irq_ff <= |((stat_evt | (irq_stat_ff & ~stat_clr)) & irq_en_ff);
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        if (hit(s_axi_araddr, `AISP_ADDR_SEL)) begin
            rd_mux[15:0] = interrupt_pair_select_ff;
        end else if (hit(s_axi_araddr, `AISP_ADDR_FLAG)) begin
            rd_mux[1:0] = interrupt_flag_bits;
        end else if (hit(s_axi_araddr, `AISP_ADDR_OVF)) begin
            rd_mux[1:0] = interrupt_overflow_bits;
        end else if (hit(s_axi_araddr, `AISP_ADDR_UNLOCK)) begin
            rd_mux[0] = protected_write_unlock_ff;
        end else if (hit(s_axi_araddr, `AISP_ADDR_IRQ_STAT)) begin
            rd_mux[3:0] = irq_stat_ff;
        end else if (hit(s_axi_araddr, `AISP_ADDR_IRQ_EN)) begin
            rd_mux[3:0] = irq_en_ff;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AISP_RESP_OKAY;
            r_pend_ff <= 1'b0;
        end else begin
            s_axi_arready <= 1'b0;
            r_pend_ff <= 1'b0;
            if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid & ~r_pend_ff) begin
                s_axi_arready <= 1'b1;
                r_pend_ff <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= mapped(s_axi_araddr) ? `AISP_RESP_OKAY : `AISP_RESP_SLVERR;
            end
            // data valid only after the address handshake
            if (r_pend_ff) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // the two lines
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_line
            aisp_line u_line (
                .aclk(aclk),
                .aresetn(aresetn),
                .cfg(interrupt_pair_select_ff[g * `AISP_UP_LSB +: 7]),
                .eoc(eoc_rise),
                .flag_clr(flag_clr[g]),
                .ovf_clr(ovf_clr[g]),
                .pulse_ff(line_pulse[g]),
                .flag_ff(interrupt_flag_bits[g]),
                .ovf_ff(interrupt_overflow_bits[g]),
                .ovf_evt_ff(line_ovf_evt[g])
            );
        end
    endgenerate

    // both are flip-flop outputs inside the line module
    assign converter_interrupt_lower = line_pulse[0];
    assign converter_interrupt_upper = line_pulse[1];
endmodule
